// file: rtl/adcrt_map.svh
// adcrt_map.svh: register addresses, codes, reset values and timing for the
// seven-channel range trim and calibration block.
// assumes it is included by bare name from the package and adcrt_top.
`ifndef ADCRT_MAP_SVH
`define ADCRT_MAP_SVH

// ----------------------------------------------------------------------------
// register addresses (modbus holding register numbers, as hex)
// ----------------------------------------------------------------------------
`define ADCRT_CHAN_DATA_BASE        16'h9c71
`define ADCRT_CHAN_RANGE_BASE       16'h9ca1
`define ADCRT_ZERO_TRIM_TEN_VOLT    16'h9cb2
`define ADCRT_ZERO_TRIM_FIVE_VOLT   16'h9cb3
`define ADCRT_ZERO_TRIM_ONE_VOLT    16'h9cb4
`define ADCRT_ZERO_TRIM_TENTH_VOLT  16'h9cb5
`define ADCRT_ZERO_TRIM_FIFTY_MV    16'h9cb6
`define ADCRT_ZERO_TRIM_25_MV       16'h9cb7
`define ADCRT_SPAN_TRIM_TEN_VOLT    16'h9cd2
`define ADCRT_SPAN_TRIM_FIVE_VOLT   16'h9cd3
`define ADCRT_SPAN_TRIM_ONE_VOLT    16'h9cd4
`define ADCRT_SPAN_TRIM_TENTH_VOLT  16'h9cd5
`define ADCRT_SPAN_TRIM_FIFTY_MV    16'h9cd6
`define ADCRT_SPAN_TRIM_25_MV       16'h9cd7
`define ADCRT_MODULE_COMMAND        16'h9d31
`define ADCRT_NUM_CHAN              3'h7
`define ADCRT_NUM_RANGE             3'h6

// ----------------------------------------------------------------------------
// command codes, range codes, exception codes
// ----------------------------------------------------------------------------
`define ADCRT_CMD_IDLE              16'h0000
`define ADCRT_CMD_REMOTE_RESET      16'h0001
`define ADCRT_CMD_WRITE_ENABLE      16'h0002
`define ADCRT_CMD_COMM_INIT         16'h0005
`define ADCRT_RANGE_DISABLED        3'h0
`define ADCRT_RANGE_MAX             3'h6
`define ADCRT_RANGE_RESET           3'h1
`define ADCRT_EXC_NONE              8'h00
`define ADCRT_EXC_ADDRESS           8'h02
`define ADCRT_EXC_VALUE             8'h03
`define ADCRT_EXC_ACK               8'h05
`define ADCRT_EXC_BUSY              8'h06
`define ADCRT_EXC_NAK               8'h07

// ----------------------------------------------------------------------------
// calibration values and reset values
// ----------------------------------------------------------------------------
`define ADCRT_ZERO_VALUE            16'h0000
`define ADCRT_SPAN_MIN              16'hd000
`define ADCRT_SPAN_MAX              16'hfffe
`define ADCRT_MID_SCALE             16'h8000
`define ADCRT_DATA_RESET            16'h8000
`define ADCRT_OFFSET_RESET          16'h0000
`define ADCRT_GAIN_UNITY            16'h4000
`define ADCRT_GAIN_FRAC_BITS        14

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ADCRT_CLK_HZ                250000000
`define ADCRT_CAL_TIME_S            20
`define ADCRT_CONV_PER_S            25

`endif

// file: rtl/adcrt_pkg.sv
// adcrt_pkg: types shared by the trim and calibration block.
// assumes adcrt_map.svh is on the include path.
`include "adcrt_map.svh"

package adcrt_pkg;

  // register request from the modbus protocol front end
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } adcrt_req_t;

  // register answer; exc zero means a normal reply
  typedef struct packed {
    logic        valid;
    logic [7:0]  exc;
    logic [15:0] rdata;
  } adcrt_rsp_t;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_WAIT,
    CAL_DIV
  } adcrt_cal_state_t;

endpackage : adcrt_pkg

// file: rtl/adcrt_div.sv
// adcrt_div: sequential restoring divider, one quotient bit per clock,
// quotient saturated to 16 bits.
// assumes start is a one-cycle pulse and den is nonzero.
`timescale 1ns/1ns

module adcrt_div
  import adcrt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [29:0] num,
  input  wire logic [15:0] den,
  output logic             done,
  output logic [15:0]      quo
);

  logic [16:0] rem_reg,  rem_next;
  logic [29:0] q_reg,    q_next;
  logic [15:0] den_reg,  den_next;
  logic [4:0]  cnt_reg,  cnt_next;
  logic        busy_reg, busy_next;
  logic        done_reg, done_next;
  logic [16:0] shifted;

  // one shift-and-subtract step per cycle while busy
  always_comb begin
    rem_next  = rem_reg;
    q_next    = q_reg;
    den_next  = den_reg;
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    shifted   = {rem_reg[15:0], q_reg[29]};
    if (start) begin
      rem_next  = 17'h00000;
      q_next    = num;
      den_next  = den;
      cnt_next  = 5'h1e;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (shifted >= {1'b0, den_reg}) begin
        rem_next = shifted - {1'b0, den_reg};
        q_next   = {q_reg[28:0], 1'b1};
      end else begin
        rem_next = shifted;
        q_next   = {q_reg[28:0], 1'b0};
      end
      cnt_next = cnt_reg - 5'h01;
      if (cnt_reg == 5'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  // register the divider state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rem_reg  <= 17'h00000;
      q_reg    <= 30'h00000000;
      den_reg  <= 16'h0000;
      cnt_reg  <= 5'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      rem_reg  <= rem_next;
      q_reg    <= q_next;
      den_reg  <= den_next;
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
  assign quo  = (|q_reg[29:16]) ? 16'hffff : q_reg[15:0]; // saturate

endmodule : adcrt_div

// file: rtl/adcrt_top.sv
// adcrt_top: register decode, write protection, channel ranges, conversion
// scan and zero/span trim calibration of a seven-channel analog input.
// assumes a modbus front end on clk that issues one register request at a
// time, and a converter controller on clk that answers each start with done.
`timescale 1ns/1ns
`include "adcrt_map.svh"

module adcrt_top
  import adcrt_pkg::*;
#(
  parameter logic [39:0] CAL_CYCLES  = 40'(`ADCRT_CAL_TIME_S) * 40'(`ADCRT_CLK_HZ),
  parameter logic [31:0] CONV_PERIOD = 32'(`ADCRT_CLK_HZ / `ADCRT_CONV_PER_S)
)(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire adcrt_req_t  req,
  output adcrt_rsp_t       rsp,
  output logic             conv_start,
  output logic [2:0]       conv_chan,
  output logic [2:0]       conv_range,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  output logic             remote_reset,
  output logic             comm_init,
  output logic             cal_busy
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // apply offset then gain about mid scale, saturating to 16 bits
  function automatic logic [15:0] adcrt_correct(input logic [15:0] raw,
                                                input logic [15:0] off,
                                                input logic [15:0] gain);
    logic [15:0]        c;
    logic signed [16:0] d;
    logic signed [33:0] p;
    logic signed [33:0] s;
    c = raw + off;
    d = $signed({1'b0, c}) - $signed({1'b0, `ADCRT_MID_SCALE});
    p = 34'(d) * 34'($signed({1'b0, gain}));
    s = (p >>> `ADCRT_GAIN_FRAC_BITS) + 34'($signed({1'b0, `ADCRT_MID_SCALE}));
    if (s < 0) return 16'h0000;
    if (s > 34'sh0ffff) return 16'hffff;
    return s[15:0];
  endfunction : adcrt_correct

  // register index within a block of n registers, or 3'h7 when outside it
  function automatic logic [2:0] adcrt_index(input logic [15:0] addr,
                                             input logic [15:0] base,
                                             input logic [2:0]  n);
    logic [15:0] d;
    d = addr - base;
    return (addr >= base && d < {13'h0000, n}) ? d[2:0] : 3'h7;
  endfunction : adcrt_index

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [15:0]      data_reg   [7],  data_next   [7];
  logic [2:0]       range_reg  [7],  range_next  [7];
  logic [15:0]      offset_reg [6],  offset_next [6];
  logic [15:0]      gain_reg   [6],  gain_next   [6];
  adcrt_rsp_t       rsp_reg,         rsp_next;
  logic             wen_reg,         wen_next;
  logic             rreset_reg,      rreset_next;
  logic             cinit_reg,       cinit_next;
  logic [31:0]      tick_cnt_reg,    tick_cnt_next;
  logic             pend_reg,        pend_next;
  logic             start_reg,       start_next;
  logic [2:0]       chan_reg,        chan_next;
  logic [2:0]       crange_reg,      crange_next;
  adcrt_cal_state_t cal_reg,         cal_next;
  logic             cal_busy_reg,    cal_busy_next;
  logic             cal_span_reg,    cal_span_next;
  logic [2:0]       cal_idx_reg,     cal_idx_next;
  logic [15:0]      cal_target_reg,  cal_target_next;
  logic [39:0]      cal_cnt_reg,     cal_cnt_next;
  logic [15:0]      sample_reg,      sample_next;
  logic             have_reg,        have_next;
  logic             div_start_reg,   div_start_next;
  logic [29:0]      div_num_reg,     div_num_next;
  logic [15:0]      div_den_reg,     div_den_next;
  logic             div_done;
  logic [15:0]      div_quo;

  logic [2:0]  zero_idx, span_idx, data_idx, rng_idx;
  logic [2:0]  pick;
  logic        found;
  logic [15:0] meas;
  logic [2:0]  c;

  assign zero_idx = adcrt_index(req.addr, `ADCRT_ZERO_TRIM_TEN_VOLT, `ADCRT_NUM_RANGE);
  assign span_idx = adcrt_index(req.addr, `ADCRT_SPAN_TRIM_TEN_VOLT, `ADCRT_NUM_RANGE);
  assign data_idx = adcrt_index(req.addr, `ADCRT_CHAN_DATA_BASE, `ADCRT_NUM_CHAN);
  assign rng_idx  = adcrt_index(req.addr, `ADCRT_CHAN_RANGE_BASE, `ADCRT_NUM_CHAN);

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  // next enabled channel after the last one, round robin
  always_comb begin
    pick  = chan_reg;
    found = 1'b0;
    c     = chan_reg;
    for (int i = 0; i < 7; i++) begin
      c = (c == 3'h6) ? 3'h0 : c + 3'h1;
      if (!found && range_reg[c] != `ADCRT_RANGE_DISABLED) begin
        pick  = c;
        found = 1'b1;
      end
    end
  end

  // register access, scan and calibration sequencing
  always_comb begin
    data_next       = data_reg;
    range_next      = range_reg;
    offset_next     = offset_reg;
    gain_next       = gain_reg;
    wen_next        = wen_reg;
    rreset_next     = 1'b0;
    cinit_next      = 1'b0;
    rsp_next        = '0;
    tick_cnt_next   = tick_cnt_reg;
    pend_next       = pend_reg;
    start_next      = 1'b0;
    chan_next       = chan_reg;
    crange_next     = crange_reg;
    cal_next        = cal_reg;
    cal_span_next   = cal_span_reg;
    cal_idx_next    = cal_idx_reg;
    cal_target_next = cal_target_reg;
    cal_cnt_next    = cal_cnt_reg;
    sample_next     = sample_reg;
    have_next       = have_reg;
    div_start_next  = 1'b0;
    div_num_next    = div_num_reg;
    div_den_next    = div_den_reg;
    meas            = sample_reg + offset_reg[cal_idx_reg];

    // conversion scan: at most one start per tick, shared converter
    if (tick_cnt_reg == CONV_PERIOD - 32'h1) begin
      tick_cnt_next = 32'h0;
      if (!pend_reg && found) begin
        start_next  = 1'b1;
        pend_next   = 1'b1;
        chan_next   = pick;
        crange_next = range_reg[pick];
      end
    end else begin
      tick_cnt_next = tick_cnt_reg + 32'h1;
    end
    if (conv_done && pend_reg) begin
      pend_next = 1'b0;
      if (crange_reg != `ADCRT_RANGE_DISABLED) begin
        data_next[chan_reg] = adcrt_correct(conv_data, offset_reg[crange_reg - 3'h1],
                                            gain_reg[crange_reg - 3'h1]);
        if (cal_reg == CAL_WAIT && crange_reg - 3'h1 == cal_idx_reg) begin
          sample_next = conv_data;
          have_next   = 1'b1;
        end
      end
    end

    // calibration timer, then trim update
    case (cal_reg)
      CAL_IDLE: ;
      CAL_WAIT: begin
        if (cal_cnt_reg == 40'h1) begin
          cal_next = CAL_IDLE;
          if (have_reg && !cal_span_reg) begin
            offset_next[cal_idx_reg] = `ADCRT_MID_SCALE - sample_reg;
          end else if (have_reg && meas > `ADCRT_MID_SCALE) begin
            div_num_next   = {cal_target_reg - `ADCRT_MID_SCALE, 14'h0000};
            div_den_next   = meas - `ADCRT_MID_SCALE;
            div_start_next = 1'b1;
            cal_next       = CAL_DIV;
          end
        end else begin
          cal_cnt_next = cal_cnt_reg - 40'h1;
        end
      end
      CAL_DIV: begin
        if (div_done) begin
          gain_next[cal_idx_reg] = div_quo;
          cal_next = CAL_IDLE;
        end
      end
      default: cal_next = CAL_IDLE;
    endcase

    // register requests; reads always answered, even during calibration
    if (req.valid) begin
      rsp_next.valid = 1'b1;
      rsp_next.exc   = `ADCRT_EXC_NONE;
      if (!req.write) begin
        if (data_idx != 3'h7) begin
          rsp_next.rdata = data_reg[data_idx];
        end else if (rng_idx != 3'h7) begin
          rsp_next.rdata = {13'h0000, range_reg[rng_idx]};
        end else begin
          rsp_next.exc = `ADCRT_EXC_ADDRESS;
        end
      end else if (req.addr == `ADCRT_MODULE_COMMAND) begin
        case (req.wdata)
          `ADCRT_CMD_IDLE: ;
          `ADCRT_CMD_WRITE_ENABLE: wen_next = 1'b1;
          `ADCRT_CMD_COMM_INIT: cinit_next = 1'b1;
          `ADCRT_CMD_REMOTE_RESET: begin
            if (!wen_reg) begin
              rsp_next.exc = `ADCRT_EXC_NAK;
            end else begin
              rreset_next = 1'b1;
              wen_next    = 1'b0;
            end
          end
          default: rsp_next.exc = `ADCRT_EXC_VALUE;
        endcase
      end else if (rng_idx != 3'h7) begin
        if (!wen_reg) begin
          rsp_next.exc = `ADCRT_EXC_NAK;
        end else if (req.wdata > {13'h0000, `ADCRT_RANGE_MAX}) begin
          rsp_next.exc = `ADCRT_EXC_VALUE;
        end else begin
          range_next[rng_idx] = req.wdata[2:0];
          wen_next = 1'b0;
        end
      end else if (zero_idx != 3'h7 || span_idx != 3'h7) begin
        if (!wen_reg) begin
          rsp_next.exc = `ADCRT_EXC_NAK;
        end else if (cal_reg != CAL_IDLE) begin
          rsp_next.exc = `ADCRT_EXC_BUSY;
        end else if (zero_idx != 3'h7 && req.wdata != `ADCRT_ZERO_VALUE) begin
          rsp_next.exc = `ADCRT_EXC_VALUE;
        end else if (span_idx != 3'h7 &&
                     (req.wdata < `ADCRT_SPAN_MIN || req.wdata > `ADCRT_SPAN_MAX)) begin
          rsp_next.exc = `ADCRT_EXC_VALUE;
        end else begin
          rsp_next.exc    = `ADCRT_EXC_ACK;
          wen_next        = 1'b0;
          cal_next        = CAL_WAIT;
          cal_span_next   = (span_idx != 3'h7);
          cal_idx_next    = (span_idx != 3'h7) ? span_idx : zero_idx;
          cal_target_next = req.wdata;
          cal_cnt_next    = CAL_CYCLES;
          have_next       = 1'b0;
        end
      end else begin
        rsp_next.exc = `ADCRT_EXC_ADDRESS;
      end
    end

    // busy follows the calibration state, registered so the output is a flop
    cal_busy_next = (cal_next != CAL_IDLE);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 7; i++) begin
        data_reg[i]  <= `ADCRT_DATA_RESET;
        range_reg[i] <= `ADCRT_RANGE_RESET;
      end
      for (int i = 0; i < 6; i++) begin
        offset_reg[i] <= `ADCRT_OFFSET_RESET;
        gain_reg[i]   <= `ADCRT_GAIN_UNITY;
      end
      rsp_reg        <= '0;
      wen_reg        <= 1'b0;
      rreset_reg     <= 1'b0;
      cinit_reg      <= 1'b0;
      tick_cnt_reg   <= 32'h0;
      pend_reg       <= 1'b0;
      start_reg      <= 1'b0;
      chan_reg       <= 3'h6;
      crange_reg     <= 3'h0;
      cal_reg        <= CAL_IDLE;
      cal_busy_reg   <= 1'b0;
      cal_span_reg   <= 1'b0;
      cal_idx_reg    <= 3'h0;
      cal_target_reg <= 16'h0000;
      cal_cnt_reg    <= 40'h0;
      sample_reg     <= 16'h0000;
      have_reg       <= 1'b0;
      div_start_reg  <= 1'b0;
      div_num_reg    <= 30'h0;
      div_den_reg    <= 16'h0001;
    end else begin
      data_reg       <= data_next;
      range_reg      <= range_next;
      offset_reg     <= offset_next;
      gain_reg       <= gain_next;
      rsp_reg        <= rsp_next;
      wen_reg        <= wen_next;
      rreset_reg     <= rreset_next;
      cinit_reg      <= cinit_next;
      tick_cnt_reg   <= tick_cnt_next;
      pend_reg       <= pend_next;
      start_reg      <= start_next;
      chan_reg       <= chan_next;
      crange_reg     <= crange_next;
      cal_reg        <= cal_next;
      cal_busy_reg   <= cal_busy_next;
      cal_span_reg   <= cal_span_next;
      cal_idx_reg    <= cal_idx_next;
      cal_target_reg <= cal_target_next;
      cal_cnt_reg    <= cal_cnt_next;
      sample_reg     <= sample_next;
      have_reg       <= have_next;
      div_start_reg  <= div_start_next;
      div_num_reg    <= div_num_next;
      div_den_reg    <= div_den_next;
    end
  end

  // span gain divider
  adcrt_div u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (div_start_reg),
    .num     (div_num_reg),
    .den     (div_den_reg),
    .done    (div_done),
    .quo     (div_quo)
  );

  // outputs straight from flip-flops
  assign rsp          = rsp_reg;
  assign conv_start   = start_reg;
  assign conv_chan    = chan_reg;
  assign conv_range   = crange_reg;
  assign remote_reset = rreset_reg;
  assign comm_init    = cinit_reg;
  assign cal_busy     = cal_busy_reg;

endmodule : adcrt_top

// file: tb/adcrt_top_properties.sv
// adcrt_top_properties: port-level checks on adcrt_top.
// assumes it is bound into adcrt_top and runs on clk with sys_rst.
`timescale 1ns/1ns

module adcrt_top_properties
  import adcrt_pkg::*;
#(
  parameter logic [39:0] CAL_CYCLES  = 40'hc8,
  parameter logic [31:0] CONV_PERIOD = 32'h14
)(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire adcrt_req_t  req,
  input wire adcrt_rsp_t  rsp,
  input wire logic        conv_start,
  input wire logic [2:0]  conv_chan,
  input wire logic [2:0]  conv_range,
  input wire logic        conv_done,
  input wire logic [15:0] conv_data,
  input wire logic        remote_reset,
  input wire logic        comm_init,
  input wire logic        cal_busy
);
  // timer plus divider, with margin, for the short bench calibration
  localparam int CAL_MAX = 600;
  logic cmd_wr, cmd1, cmd5, cmd_bad, trim_wr;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // decode of the request taken at this edge
  assign cmd_wr  = req.valid && req.write && req.addr == 16'h9d31;
  assign cmd1    = cmd_wr && req.wdata == 16'h0001;
  assign cmd5    = cmd_wr && req.wdata == 16'h0005;
  assign cmd_bad = cmd_wr && !(req.wdata inside {16'h0, 16'h1, 16'h2, 16'h5});
  assign trim_wr = req.valid && req.write &&
                   (req.addr inside {[16'h9cb2:16'h9cb7], [16'h9cd2:16'h9cd7]});

  sequence s_trim_ack;
    rsp.valid && rsp.exc == 8'h05;
  endsequence
  sequence s_cal_hold;
    cal_busy [*8];
  endsequence

  a_reply_next: assert property (req.valid |=> rsp.valid)
    else $error("reply missing");
  a_cal_hold: assert property (s_trim_ack |-> s_cal_hold)
    else $error("calibration ended early");
  a_cal_cause: assert property ($rose(cal_busy) |-> $past(trim_wr))
    else $error("calibration without trim");
  a_cal_ends: assert property ($rose(cal_busy) |-> ##[1:CAL_MAX] !cal_busy)
    else $error("calibration hangs");
  a_busy_refuse: assert property (cal_busy && trim_wr |=> rsp.exc != 8'h05)
    else $error("second trim taken");
  a_bad_cmd: assert property (cmd_bad |=> rsp.exc == 8'h03)
    else $error("bad command accepted");
  a_comm_pulse: assert property (cmd5 |-> ##[1:2] comm_init)
    else $error("comm init missing");
  a_reset_cause: assert property (remote_reset |-> $past(cmd1) || $past(cmd1, 2))
    else $error("stray remote reset");
  a_start_legal: assert property (conv_start |->
    conv_range inside {[3'h1:3'h6]} && conv_chan <= 3'h6) else $error("bad conversion start");
  a_start_gap: assert property (conv_start |=> !conv_start [*8])
    else $error("starts too close");
endmodule : adcrt_top_properties

// file: tb/adcrt_conv_model.sv
// adcrt_conv_model: converter controller that answers each start.
// assumes raw_val and lat are held steady by the bench.
`timescale 1ns/1ns

module adcrt_conv_model (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        conv_start,
  input wire logic [15:0] raw_val,
  input wire logic [5:0]  lat,
  output logic            conv_done,
  output logic [15:0]     conv_data
);
  logic [5:0]  cnt;
  logic        busy;
  logic [15:0] last;

  // one conversion at a time, done lat+1 cycles after the start is taken
  always_ff @(posedge clk) begin
    conv_done <= 1'b0;
    if (sys_rst) begin
      busy <= 1'b0;
      cnt  <= 6'h0;
      last <= 16'h0;
    end else if (conv_start) begin
      busy <= 1'b1;
      cnt  <= lat;
    end else if (busy && cnt == 6'h0) begin
      busy      <= 1'b0;
      conv_done <= 1'b1;
      last      <= raw_val;
    end else if (busy) begin
      cnt <= cnt - 6'h1;
    end
  end

  // data is only good with done; otherwise show the inverse
  assign conv_data = conv_done ? last : ~last;
endmodule : adcrt_conv_model

// file: tb/adc_range_trim_calibration_test.sv
// adc_range_trim_calibration_test: self-checking bench for adcrt_top.
// assumes short calibration and conversion periods via parameters.
`timescale 1ns/1ns

module adc_range_trim_calibration_test
  import adcrt_pkg::*;
();
  localparam logic [39:0] CAL = 40'hc8;
  localparam logic [31:0] PER = 32'h14;
  logic        clk, sys_rst, conv_start, conv_done, remote_reset, comm_init, cal_busy;
  logic [2:0]  conv_chan, conv_range;
  logic [15:0] conv_data, raw_val;
  logic [5:0]  lat;
  adcrt_req_t  req;
  adcrt_rsp_t  rsp;
  int          fail_count = 0, n_checks = 0, cycles = 0, n_rr = 0, n_ci = 0, n_st = 0;

  adcrt_top #(.CAL_CYCLES(CAL), .CONV_PERIOD(PER)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .req(req), .rsp(rsp), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_range(conv_range), .conv_done(conv_done), .conv_data(conv_data),
    .remote_reset(remote_reset), .comm_init(comm_init), .cal_busy(cal_busy));
  adcrt_conv_model i_conv (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start),
    .raw_val(raw_val), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one register request, answer judged the cycle after
  task automatic rg(input logic w, input logic [15:0] a, input logic [15:0] d,
                    input logic [7:0] x, input logic [15:0] rd);
    req = '{1'b1, w, a, d};
    @(negedge clk);
    chk({7'h0, rsp.valid, rsp.exc}, {8'h01, x});
    chk(rsp.rdata, rd);
    req.valid = 1'b0;
    @(negedge clk);
  endtask : rg

  task automatic en();
    rg(1'h1, 16'h9d31, 16'h0002, 8'h0, 16'h0);
  endtask : en

  task automatic set_all(input logic [2:0] r);
    for (int i = 0; i < 7; i++) begin
      en();
      rg(1'h1, 16'h9ca1 + 16'(i), {13'h0, r}, 8'h0, 16'h0);
    end
  endtask : set_all

  task automatic read_all(input logic [15:0] v);
    for (int i = 0; i < 7; i++) rg(1'h0, 16'h9c71 + 16'(i), 16'h0, 8'h0, v);
  endtask : read_all

  task automatic wait_idle();
    for (int i = 0; i < 1000 && cal_busy !== 1'b0; i++) @(negedge clk);
    chk({15'h0, cal_busy}, 16'h0);
  endtask : wait_idle

  task automatic next_start();
    @(negedge clk);
    for (int i = 0; i < 300 && conv_start !== 1'b1; i++) @(negedge clk);
    chk({15'h0, conv_start}, 16'h1);
  endtask : next_start

  task automatic t_reset_vals();
    read_all(16'h8000);
    for (int i = 0; i < 7; i++) rg(1'h0, 16'h9ca1 + 16'(i), 16'h0, 8'h0, 16'h1);
  endtask : t_reset_vals

  task automatic t_access();
    rg(1'h0, 16'h9c70, 16'h0, 8'h02, 16'h0);
    rg(1'h0, 16'h9cd2, 16'h0, 8'h02, 16'h0);
    rg(1'h1, 16'h9ca1, 16'h0003, 8'h07, 16'h0);
    rg(1'h1, 16'h9cd2, 16'hfffe, 8'h07, 16'h0);
    en();
    rg(1'h1, 16'h9ca1, 16'h0007, 8'h03, 16'h0);
    rg(1'h1, 16'h9cb2, 16'h0001, 8'h03, 16'h0);
    rg(1'h1, 16'h9cd2, 16'hcfff, 8'h03, 16'h0);
    rg(1'h1, 16'h9ca1, 16'h0001, 8'h0, 16'h0);
    rg(1'h1, 16'h9ca1, 16'h0001, 8'h07, 16'h0);
  endtask : t_access

  task automatic t_commands();
    rg(1'h1, 16'h9d31, 16'h0000, 8'h0, 16'h0);
    rg(1'h1, 16'h9d31, 16'h0003, 8'h03, 16'h0);
    rg(1'h1, 16'h9d31, 16'h0005, 8'h0, 16'h0);
    rg(1'h1, 16'h9d31, 16'h0001, 8'h07, 16'h0);
    en();
    rg(1'h1, 16'h9d31, 16'h0001, 8'h0, 16'h0);
    chk(16'(n_ci), 16'h1);
    chk(16'(n_rr), 16'h1);
  endtask : t_commands

  // channel i gets range code i, so channel 0 is off
  task automatic t_scan();
    logic [2:0] c;
    int         s;
    for (int i = 0; i < 7; i++) begin
      en();
      rg(1'h1, 16'h9ca1 + 16'(i), 16'(i), 8'h0, 16'h0);
    end
    next_start();
    c = conv_chan;
    repeat (12) begin
      next_start();
      c = (c == 3'h6) ? 3'h1 : c + 3'h1;
      chk({13'h0, conv_chan}, {13'h0, c});
      chk({13'h0, conv_range}, {13'h0, c});
    end
    set_all(3'h0);
    repeat (40) @(negedge clk);
    s = n_st;
    repeat (100) @(negedge clk);
    chk(16'(n_st - s), 16'h0);
  endtask : t_scan

  // zero trims widest range first, offset input reads mid scale
  task automatic t_zero();
    raw_val = 16'h8123;
    for (int r = 1; r < 7; r++) begin
      set_all(3'(r));
      en();
      rg(1'h1, 16'h9cb1 + 16'(r), 16'h0, 8'h05, 16'h0);
      chk({15'h0, cal_busy}, 16'h1);
      wait_idle();
      repeat (10 * PER) @(negedge clk);
      read_all(16'h8000);
    end
  endtask : t_zero

  // span trims narrowest first, slow converter, busy refusal
  task automatic t_span();
    raw_val = 16'hc123;
    lat = 6'h19;
    for (int r = 6; r > 0; r--) begin
      set_all(3'(r));
      en();
      rg(1'h1, 16'h9cd1 + 16'(r), 16'hfffe, 8'h05, 16'h0);
      en();
      rg(1'h1, 16'h9cd1 + 16'(r), 16'hfffe, 8'h06, 16'h0);
      rg(1'h0, 16'h9ca1, 16'h0, 8'h0, 16'(r));
      wait_idle();
      repeat (20 * PER) @(negedge clk);
      read_all(16'hfffe);
    end
  endtask : t_span

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // pulse counters and hang guard
  always @(posedge clk) begin
    cycles++;
    if (!sys_rst) begin
      n_rr += int'(remote_reset);
      n_ci += int'(comm_init);
      n_st += int'(conv_start);
    end
    if (cycles == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    sys_rst = 1'b1;
    req = '0;
    raw_val = 16'h8000;
    lat = 6'h2;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    t_reset_vals();
    t_access();
    t_commands();
    t_scan();
    t_zero();
    t_span();
    give_verdict();
  end
endmodule : adc_range_trim_calibration_test

bind adcrt_top adcrt_top_properties #(.CAL_CYCLES(CAL_CYCLES), .CONV_PERIOD(CONV_PERIOD))
  i_props (.clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp), .conv_start(conv_start),
  .conv_chan(conv_chan), .conv_range(conv_range), .conv_done(conv_done),
  .conv_data(conv_data), .remote_reset(remote_reset), .comm_init(comm_init),
  .cal_busy(cal_busy));
